// ===== core/flash_ctrl_map.svh
// Register offsets, field positions, reset values and timing counts of the flash controller
`ifndef FLASH_CTRL_MAP_SVH
`define FLASH_CTRL_MAP_SVH

`define ADDR_LOW_OFS 8'h00
`define ADDR_HIGH_OFS 8'h04
`define DATA_LOW_OFS 8'h08
`define DATA_HIGH_OFS 8'h0C
`define CTRL_OFS 8'h10
`define KEY_OFS 8'h14
`define IRQ_STATUS_OFS 8'h18
`define IRQ_MASK_OFS 8'h1C

`define CTRL_RD 0
`define CTRL_WR 1
`define CTRL_WRITE_ENABLE 2
`define CTRL_WRITE_ERROR_FLAG 3
`define CTRL_ERASE 4
`define CTRL_LATCH_ONLY 5
`define CTRL_CONFIG_SPACE_SELECT 6

`define IRQ_DONE 0
`define IRQ_REJECT 1
`define IRQ_WRITE_ERROR_FLAG 2
`define IRQ_MASK_RST 3'h0

`define UNLOCK_KEY1 8'h55
`define UNLOCK_KEY2 8'hAA
`define LATCH_ERASED 14'h3FFF
`define WP_QUARTER 15'h0200
`define WP_HALF 15'h0400

`define CLK_PERIOD_NS 100
`define WRITE_TIME_NS 2000000
`define WRITE_CYCLES ((`WRITE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define INSTR_CLKS 4
`define READ_STALL_INSTR 2

`endif

// ===== core/flash_ctrl_pkg.sv
// Types shared by the flash controller modules
package flash_ctrl_pkg;

	typedef enum logic [2:0] {ST_IDLE, ST_READ, ST_PROG, ST_WAIT} op_state_e;

	typedef struct packed {
		logic        rd;
		logic        erase;
		logic        prog;
		logic        cfg;
		logic [14:0] addr;
		logic [13:0] wdata;
	} mem_req_s;

	typedef struct packed {
		logic        ap_valid;
		logic        ap_write;
		logic [7:0]  ap_addr;
		logic [31:0] hrdata;
		logic [14:0] addr;
		logic [13:0] data;
		logic        rd;
		logic        wr;
		logic        write_enable;
		logic        write_error_flag;
		logic        erase;
		logic        latch_only;
		logic        config_space_select;
		logic [1:0]  key_stage;
		op_state_e   op;
		logic [3:0]  idx;
		logic [1:0]  stall_cnt;
		logic [2:0]  irq_status;
		logic [2:0]  irq_mask;
		logic        boot_seen;
		logic        cp_active;
		mem_req_s    mem;
		logic        timer_start;
		logic        lat_we;
		logic        lat_clr;
	} ctl_state_s;

endpackage : flash_ctrl_pkg

// ===== core/flash_op_timer.sv
// Self-timed erase/write timer and instruction-cycle enable divider
`timescale 1ns/1ps
`include "flash_ctrl_map.svh"
module flash_op_timer #(
	parameter int WRITE_CYCLES = `WRITE_CYCLES
) (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic rst_n,
	// Control
	input  wire logic start,
	output logic      busy,
	output logic      done,
	output logic      instr_tick
);
	typedef struct packed {
		logic [15:0] cnt;
		logic        busy;
		logic        done;
		logic [1:0]  div;
	} tmr_s;

	tmr_s s;
	tmr_s n;

	// Count down the write time; software has no say in its length
	always_comb begin
		n = s;
		n.done = 1'b0;
		n.div = (s.div == 2'(`INSTR_CLKS - 1)) ? 2'h0 : s.div + 2'h1;
		if (start) begin
			n.busy = 1'b1;
			n.cnt = 16'(WRITE_CYCLES - 1);
		end else if (s.busy) begin
			if (s.cnt == 16'h0000) begin
				n.busy = 1'b0;
				n.done = 1'b1;
			end else begin
				n.cnt = s.cnt - 16'h0001;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign busy = s.busy;
	assign done = s.done;
	assign instr_tick = (s.div == 2'(`INSTR_CLKS - 1));

endmodule : flash_op_timer

// ===== core/flash_write_latches.sv
// Sixteen hidden 14-bit write latches, loaded only through the data pair
`timescale 1ns/1ps
`include "flash_ctrl_map.svh"
module flash_write_latches (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// Load side
	input  wire logic        we,
	input  wire logic [3:0]  wr_idx,
	input  wire logic [13:0] wr_data,
	input  wire logic        clr,
	// Drain side
	input  wire logic [3:0]  rd_idx,
	output logic      [13:0] rd_data
);
	typedef struct packed {
		logic [15:0][13:0] word;
	} lat_s;

	lat_s s;
	lat_s n;

	// Latches return to the erased pattern after each row write
	always_comb begin
		n = s;
		if (clr) begin
			n.word = {16{`LATCH_ERASED}};
		end else if (we) begin
			n.word[wr_idx] = wr_data;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= {16{`LATCH_ERASED}};
		end else begin
			s <= n;
		end
	end

	assign rd_data = s.word[rd_idx];

endmodule : flash_write_latches

// ===== core/self_program_flash_control.sv
// Self-programming flash controller: AHB-Lite registers, read, row erase and row write sequencer
// Function
// R01: Data pair holds 14-bit word, read and write
// R02: Address pair forms 15-bit program address
// R03: Address reaches any word of 32K space
// R04: Erase and write timed by internal timer
// R05: Code protect blocks external programmer only
// R06: Only bulk erase removes code protection
// R07: Write protect range refuses self erase/write
// R08: Strobes set by software, cleared by hardware
// R09: Writes need write enable, cleared at reset
// R10: Reset during write sets write error flag
// R11: Key port is write-only, reads zero
// R12: Unlock sequence required before any write
// R13: Rows of 16 words; row is erase unit
// R14: Sixteen 14-bit latches filled via data pair
// R15: Firmware saves row before partial rewrite
// R16: Firmware clears config select before reads
// R17: Read stalls two instruction slots
// R18: Processor stalled during timed erase/write
//
// Decided for this implementation: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "flash_ctrl_map.svh"
module self_program_flash_control #(
	parameter int WRITE_CYCLES = `WRITE_CYCLES
) (
	// Clock and reset
	input  wire logic                      core_clk,
	input  wire logic                      rstn,
	// AHB-Lite slave
	input  wire logic                      hsel,
	input  wire logic [31:0]               haddr,
	input  wire logic [1:0]                htrans,
	input  wire logic                      hwrite,
	input  wire logic [2:0]                hsize,
	input  wire logic [31:0]               hwdata,
	input  wire logic                      hready,
	output logic                           hreadyout,
	output logic                           hresp,
	output logic      [31:0]               hrdata,
	// Flash array
	output flash_ctrl_pkg::mem_req_s       mem_req,
	input  wire logic [13:0]               mem_rdata,
	// Configuration and programmer side
	input  wire logic                      code_protect,
	input  wire logic [1:0]                write_protect_range,
	input  wire logic                      ext_bulk_erase,
	input  wire logic                      write_aborted,
	output logic                           ext_access_block,
	output logic                           write_in_progress,
	// Processor
	output logic                           cpu_stall,
	output logic                           irq
);
	flash_ctrl_pkg::ctl_state_s s;
	flash_ctrl_pkg::ctl_state_s n;
	logic [1:0]  rst_sync;
	logic        rst_n;
	logic [2:0]  ev;
	logic [13:0] lat_rdata;
	logic        tmr_busy;
	logic        tmr_done;
	logic        instr_tick;

	// Write protection decode: 11 none, 10 lowest quarter, 01 lower half, 00 whole array
	function automatic logic wp_hit(input logic [1:0] range, input logic [14:0] a);
		case (range)
			2'b11: wp_hit = 1'b0;
			2'b10: wp_hit = (a < `WP_QUARTER);
			2'b01: wp_hit = (a < `WP_HALF);
			default: wp_hit = 1'b1;
		endcase
	endfunction : wp_hit

	// Reset release through two flops
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	flash_op_timer #(
		.WRITE_CYCLES(WRITE_CYCLES)
	) u_timer (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.start     (s.timer_start),
		.busy      (tmr_busy),
		.done      (tmr_done),
		.instr_tick(instr_tick)
	);

	flash_write_latches u_latches (
		.core_clk(core_clk),
		.rst_n   (rst_n),
		.we      (s.lat_we),
		.wr_idx  (s.addr[3:0]),
		.wr_data (s.data),
		.clr     (s.lat_clr),
		.rd_idx  (s.idx),
		.rd_data (lat_rdata)
	);

	// Bus access, sequencer and interrupt status in one next-state block
	always_comb begin
		n = s;
		ev = 3'h0;
		n.mem.rd = 1'b0;
		n.mem.erase = 1'b0;
		n.mem.prog = 1'b0;
		n.timer_start = 1'b0;
		n.lat_we = 1'b0;
		n.lat_clr = 1'b0;
		// Address phase: only word transfers are expected
		if (hready) begin
			n.ap_valid = hsel & htrans[1];
			n.ap_write = hwrite;
			n.ap_addr = haddr[7:0];
		end
		// Data phase of a read: one wait state loads hrdata from flops
		if (s.ap_valid && !s.ap_write) begin
			n.ap_valid = 1'b0;
			case (s.ap_addr)
				`ADDR_LOW_OFS: n.hrdata = {24'h000000, s.addr[7:0]}; // R02
				`ADDR_HIGH_OFS: n.hrdata = {25'h0000000, s.addr[14:8]}; // R03
				`DATA_LOW_OFS: n.hrdata = {24'h000000, s.data[7:0]}; // R01
				`DATA_HIGH_OFS: n.hrdata = {26'h0000000, s.data[13:8]};
				`CTRL_OFS: n.hrdata = {25'h0000000, s.config_space_select, s.latch_only, s.erase, s.write_error_flag, s.write_enable, s.wr, s.rd};
				`KEY_OFS: n.hrdata = 32'h00000000; // R11
				`IRQ_STATUS_OFS: n.hrdata = {29'h00000000, s.irq_status};
				`IRQ_MASK_OFS: n.hrdata = {29'h00000000, s.irq_mask};
				default: n.hrdata = 32'h00000000;
			endcase
		end
		// Data phase of a write; any write other than the key breaks the unlock sequence
		if (s.ap_valid && s.ap_write) begin
			if (s.ap_addr != `KEY_OFS) begin
				n.key_stage = 2'h0; // R12
			end
			case (s.ap_addr)
				`ADDR_LOW_OFS: n.addr[7:0] = hwdata[7:0];
				`ADDR_HIGH_OFS: n.addr[14:8] = hwdata[6:0]; // R02
				`DATA_LOW_OFS: n.data[7:0] = hwdata[7:0];
				`DATA_HIGH_OFS: n.data[13:8] = hwdata[5:0]; // R01
				`KEY_OFS: begin
					if (hwdata[7:0] == `UNLOCK_KEY1) begin
						n.key_stage = 2'h1;
					end else if (s.key_stage == 2'h1 && hwdata[7:0] == `UNLOCK_KEY2) begin
						n.key_stage = 2'h2; // R12
					end else begin
						n.key_stage = 2'h0;
					end
				end
				`IRQ_STATUS_OFS: n.irq_status = s.irq_status & ~hwdata[2:0];
				`IRQ_MASK_OFS: n.irq_mask = hwdata[2:0];
				`CTRL_OFS: begin
					n.key_stage = 2'h0;
					n.write_enable = hwdata[`CTRL_WRITE_ENABLE];
					n.write_error_flag = hwdata[`CTRL_WRITE_ERROR_FLAG];
					if (s.op == flash_ctrl_pkg::ST_IDLE) begin
						n.erase = hwdata[`CTRL_ERASE];
						n.latch_only = hwdata[`CTRL_LATCH_ONLY];
						n.config_space_select = hwdata[`CTRL_CONFIG_SPACE_SELECT];
					end
					// Writing zero to a strobe has no effect
					if (hwdata[`CTRL_RD] && s.op == flash_ctrl_pkg::ST_IDLE) begin // R08
						n.rd = 1'b1;
						n.op = flash_ctrl_pkg::ST_READ;
						n.stall_cnt = 2'h0;
						n.mem.rd = 1'b1;
						n.mem.addr = s.addr;
						n.mem.cfg = hwdata[`CTRL_CONFIG_SPACE_SELECT]; // R16
					end else if (hwdata[`CTRL_WR] && s.op == flash_ctrl_pkg::ST_IDLE) begin
						if (s.key_stage != 2'h2 || !hwdata[`CTRL_WRITE_ENABLE]) begin
							ev[`IRQ_REJECT] = 1'b1; // R12 R09
						end else if (hwdata[`CTRL_LATCH_ONLY] && !hwdata[`CTRL_ERASE]) begin
							n.lat_we = 1'b1; // R14
						end else if (wp_hit(write_protect_range, s.addr)) begin
							ev[`IRQ_REJECT] = 1'b1; // R07
						end else if (hwdata[`CTRL_ERASE]) begin
							n.wr = 1'b1;
							n.op = flash_ctrl_pkg::ST_WAIT;
							n.mem.erase = 1'b1;
							n.mem.addr = {s.addr[14:4], 4'h0}; // R13
							n.mem.cfg = 1'b0;
							n.timer_start = 1'b1; // R04
						end else begin
							n.wr = 1'b1;
							n.lat_we = 1'b1;
							n.op = flash_ctrl_pkg::ST_PROG;
							n.idx = 4'h0;
						end
					end
				end
				default: begin
				end
			endcase
		end
		// Sequencer
		case (s.op)
			flash_ctrl_pkg::ST_READ: begin
				if (s.mem.rd) begin
					n.data = mem_rdata; // R01
				end
				if (instr_tick) begin
					n.stall_cnt = s.stall_cnt + 2'h1;
					if (s.stall_cnt == 2'(`READ_STALL_INSTR - 1)) begin // R17
						n.rd = 1'b0;
						n.op = flash_ctrl_pkg::ST_IDLE;
						ev[`IRQ_DONE] = 1'b1;
					end
				end
			end
			flash_ctrl_pkg::ST_PROG: begin
				// Load latch settles one cycle, then stream all sixteen latches to the row
				if (!s.lat_we) begin
					n.mem.prog = 1'b1;
					n.mem.cfg = 1'b0;
					n.mem.addr = {s.addr[14:4], s.idx};
					n.mem.wdata = lat_rdata; // R14
					n.idx = s.idx + 4'h1;
					if (s.idx == 4'hF) begin
						n.op = flash_ctrl_pkg::ST_WAIT;
						n.timer_start = 1'b1; // R04
						n.lat_clr = 1'b1;
					end
				end
			end
			flash_ctrl_pkg::ST_WAIT: begin
				if (tmr_done) begin
					n.wr = 1'b0; // R08
					n.op = flash_ctrl_pkg::ST_IDLE;
					ev[`IRQ_DONE] = 1'b1;
				end
			end
			default: begin
			end
		endcase
		// Boot: catch strap and aborted-write report after reset release
		if (!s.boot_seen) begin
			n.boot_seen = 1'b1;
			n.cp_active = ~code_protect; // R05
			if (write_aborted) begin
				n.write_error_flag = 1'b1; // R10
				ev[`IRQ_WRITE_ERROR_FLAG] = 1'b1;
			end
		end
		if (ext_bulk_erase) begin
			n.cp_active = 1'b0; // R06
		end
		// Hardware set wins over a same-cycle software clear
		n.irq_status = n.irq_status | ev;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
			s.op <= flash_ctrl_pkg::ST_IDLE;
			s.irq_mask <= `IRQ_MASK_RST;
		end else begin
			s <= n;
		end
	end

	// Outputs
	assign hreadyout = ~(s.ap_valid & ~s.ap_write);
	assign hresp = 1'b0;
	assign hrdata = s.hrdata;
	assign mem_req = s.mem;
	assign ext_access_block = s.cp_active; // R05
	assign write_in_progress = (s.op == flash_ctrl_pkg::ST_PROG) || (s.op == flash_ctrl_pkg::ST_WAIT);
	assign cpu_stall = (s.op != flash_ctrl_pkg::ST_IDLE); // R18
	assign irq = |(s.irq_status & s.irq_mask);

	// Helper: write-start attempt in the current data phase
	logic wr_try;
	assign wr_try = s.ap_valid & s.ap_write & (s.ap_addr == `CTRL_OFS) & hwdata[`CTRL_WR]
		& (s.op == flash_ctrl_pkg::ST_IDLE);

	property p_key_reads_zero;
		@(posedge core_clk) disable iff (!rst_n)
		(s.ap_valid && !s.ap_write && s.ap_addr == `KEY_OFS) |=> (hrdata == 32'h00000000);
	endproperty
	a_key_reads_zero: assert property (p_key_reads_zero) else $error("key port read not zero"); // R11

	property p_no_unlock_no_write;
		@(posedge core_clk) disable iff (!rst_n)
		(wr_try && s.key_stage != 2'h2) |=> (!s.wr && s.irq_status[`IRQ_REJECT]);
	endproperty
	a_no_unlock_no_write: assert property (p_no_unlock_no_write) else $error("write ran without unlock"); // R12

	property p_write_enable_needed;
		@(posedge core_clk) disable iff (!rst_n)
		(wr_try && !hwdata[`CTRL_WRITE_ENABLE]) |=> !s.wr;
	endproperty
	a_write_enable_needed: assert property (p_write_enable_needed) else $error("write ran with write enable clear"); // R09

	property p_wr_held;
		@(posedge core_clk) disable iff (!rst_n)
		(s.op == flash_ctrl_pkg::ST_WAIT && !tmr_done) |=> s.wr;
	endproperty
	a_wr_held: assert property (p_wr_held) else $error("write strobe cleared early"); // R08

	property p_timed_wait;
		@(posedge core_clk) disable iff (!rst_n)
		s.timer_start |=> (tmr_busy && !tmr_done) [*8];
	endproperty
	a_timed_wait: assert property (p_timed_wait) else $error("timer ended too soon"); // R04

	property p_erase_row;
		@(posedge core_clk) disable iff (!rst_n)
		s.mem.erase |-> (s.mem.addr[3:0] == 4'h0 && s.op == flash_ctrl_pkg::ST_WAIT);
	endproperty
	a_erase_row: assert property (p_erase_row) else $error("erase not row aligned"); // R13

	property p_protected;
		@(posedge core_clk) disable iff (!rst_n)
		(s.mem.erase || s.mem.prog) |-> !wp_hit(write_protect_range, s.mem.addr);
	endproperty
	a_protected: assert property (p_protected) else $error("protected area altered"); // R07

	property p_read_stall;
		@(posedge core_clk) disable iff (!rst_n)
		s.mem.rd |-> cpu_stall [*5] ##[1:8] !s.rd;
	endproperty
	a_read_stall: assert property (p_read_stall) else $error("read stall wrong length"); // R17

	property p_busy_stall;
		@(posedge core_clk) disable iff (!rst_n)
		tmr_busy |-> (cpu_stall && s.wr);
	endproperty
	a_busy_stall: assert property (p_busy_stall) else $error("processor ran during timed write"); // R18

	property p_boot_write_error_flag;
		@(posedge core_clk) disable iff (!rst_n)
		(!s.boot_seen && write_aborted) |=> (s.write_error_flag && s.irq_status[`IRQ_WRITE_ERROR_FLAG]);
	endproperty
	a_boot_write_error_flag: assert property (p_boot_write_error_flag) else $error("aborted write not flagged"); // R10

endmodule : self_program_flash_control

// ===== tb/self_program_flash_control_tb_top.sv
// Self-checking testbench of the self-programming flash controller
`timescale 1ns/1ps
`include "flash_ctrl_map.svh"
module self_program_flash_control_tb_top;
	// Short write time keeps the run small
	localparam int WC = 16;
	localparam logic [31:0] B_RD = 32'h1 << `CTRL_RD;
	localparam logic [31:0] B_WR = 32'h1 << `CTRL_WR;
	localparam logic [31:0] B_EN = 32'h1 << `CTRL_WRITE_ENABLE;
	localparam logic [31:0] B_ER = 32'h1 << `CTRL_WRITE_ERROR_FLAG;
	localparam logic [31:0] B_RE = 32'h1 << `CTRL_ERASE;
	localparam logic [31:0] B_LO = 32'h1 << `CTRL_LATCH_ONLY;

	logic                     core_clk;
	logic                     rstn;
	logic                     hsel;
	logic [31:0]              haddr;
	logic [1:0]               htrans;
	logic                     hwrite;
	logic [2:0]               hsize;
	logic [31:0]              hwdata;
	logic                     hready;
	logic                     hreadyout;
	logic                     hresp;
	logic [31:0]              hrdata;
	flash_ctrl_pkg::mem_req_s mem_req;
	logic [13:0]              mem_rdata;
	logic                     code_protect;
	logic [1:0]               write_protect_range;
	logic                     ext_bulk_erase;
	logic                     write_aborted;
	logic                     ext_access_block;
	logic                     write_in_progress;
	logic                     cpu_stall;
	logic                     irq;
	int                       err_total = 0;
	int                       tests_run = 0;
	int                       np = 0;
	int                       ne = 0;
	logic [13:0]              pw [16];
	logic [14:0]              pa;
	logic [14:0]              ea;
	logic [14:0]              ra;
	logic                     rcfg;

	// Single slave, so its ready is the bus ready
	assign hready = hreadyout;

	self_program_flash_control #(.WRITE_CYCLES(WC)) i_dut (
		.core_clk(core_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .mem_req(mem_req), .mem_rdata(mem_rdata),
		.code_protect(code_protect), .write_protect_range(write_protect_range),
		.ext_bulk_erase(ext_bulk_erase), .write_aborted(write_aborted),
		.ext_access_block(ext_access_block), .write_in_progress(write_in_progress),
		.cpu_stall(cpu_stall), .irq(irq));

	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	// Flash array stand-in: the word stands only with the read pulse, so a late capture sees the inverse
	assign mem_rdata = mem_req.rd ? (mem_req.addr[13:0] ^ 14'h2C3A) : ~(mem_req.addr[13:0] ^ 14'h2C3A);

	// Record what the controller asked of the array
	always @(posedge core_clk) begin
		if (mem_req.rd) {rcfg, ra} <= {mem_req.cfg, mem_req.addr};
		if (mem_req.prog) begin
			np <= np + 1;
			pw[mem_req.addr[3:0]] <= mem_req.wdata;
			pa <= mem_req.addr;
		end
		if (mem_req.erase) begin
			ne <= ne + 1;
			ea <= mem_req.addr;
		end
	end

	task automatic stop_test();
		$display("tests_run=%0d err_total=%0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : stop_test

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	// Looks at ready half a cycle early, so the deciding edge is never raced
	task automatic wait_rdy(output logic [31:0] q);
		int n;
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		q = hrdata;
		if (n >= 50) begin
			err_total++;
			stop_test();
		end
		@(posedge core_clk);
	endtask : wait_rdy

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		wait_rdy(q);
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy(q);
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		bus(1'b0, a, 32'h0, q);
	endtask : rd

	// Counts stalled cycles until the processor is released
	task automatic wait_done(output int n);
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (cpu_stall !== 1'b0 && n < 400);
		if (n >= 400) begin
			err_total++;
			stop_test();
		end
		@(posedge core_clk);
	endtask : wait_done

	task automatic irq_is(input logic e);
		@(negedge core_clk);
		check("irq", irq, e);
		@(posedge core_clk);
	endtask : irq_is

	// One self-write attempt: address, data, optional unlock, control write
	task automatic attempt(input logic [14:0] a, input logic [13:0] d, input logic [31:0] c,
			input bit key, input logic rej, output int n);
		int n0;
		int e0;
		logic [31:0] q;
		n0 = np;
		e0 = ne;
		wr(`ADDR_LOW_OFS, {24'h0, a[7:0]});
		wr(`ADDR_HIGH_OFS, {25'h0, a[14:8]});
		wr(`DATA_LOW_OFS, {24'h0, d[7:0]});
		wr(`DATA_HIGH_OFS, {26'h0, d[13:8]});
		if (key) begin
			wr(`KEY_OFS, {24'h0, `UNLOCK_KEY1});
			wr(`KEY_OFS, {24'h0, `UNLOCK_KEY2});
		end
		wr(`CTRL_OFS, c);
		wait_done(n);
		rd(`IRQ_STATUS_OFS, q);
		check("reject", q[`IRQ_REJECT], rej);
		wr(`IRQ_STATUS_OFS, 32'h7);
		if (rej)
			check("pulses", np - n0 + ne - e0, 0);
		else if (c[`CTRL_ERASE]) begin
			check("erases", ne - e0, 1);
			check("erase_row", ea[14:4], a[14:4]);
		end
	endtask : attempt

	task automatic t_boot();
		logic [31:0] q;
		rd(`CTRL_OFS, q);
		check("ctrl_rst", q, B_ER);
		rd(`IRQ_STATUS_OFS, q);
		check("stat_rst", q, 32'h1 << `IRQ_WRITE_ERROR_FLAG);
		rd(`IRQ_MASK_OFS, q);
		check("mask_rst", q, 32'h0);
		check("hresp", hresp, 1'b0);
		wr(`KEY_OFS, 32'h55);
		rd(`KEY_OFS, q);
		check("key_rd", q, 32'h0);
		rd(8'h40, q);
		check("unmapped", q, 32'h0);
		irq_is(1'b0);
		wr(`IRQ_MASK_OFS, 32'h7);
		irq_is(1'b1);
		wr(`IRQ_STATUS_OFS, 32'h1 << `IRQ_WRITE_ERROR_FLAG);
		irq_is(1'b0);
		wr(`CTRL_OFS, 32'h0);
		rd(`CTRL_OFS, q);
		check("write_error_flag_clr", q, 32'h0);
		$display("test boot done");
	endtask : t_boot

	task automatic t_read();
		logic [31:0] lo;
		logic [31:0] hi;
		logic [13:0] e;
		int n;
		e = 14'h3F34 ^ 14'h2C3A;
		wr(`ADDR_LOW_OFS, 32'h34);
		wr(`ADDR_HIGH_OFS, 32'h7F);
		wr(`CTRL_OFS, B_RD);
		wait_done(n);
		check("rd_addr", ra, 15'h7F34);
		check("rd_cfg", rcfg, 1'b0);
		check("rd_stall", (n - 1 >= 5) && (n - 1 <= 8), 1);
		rd(`DATA_LOW_OFS, lo);
		rd(`DATA_HIGH_OFS, hi);
		check("rd_data", {hi[5:0], lo[7:0]}, e);
		rd(`CTRL_OFS, lo);
		check("rd_strobe", lo & B_RD, 32'h0);
		irq_is(1'b1);
		wr(`IRQ_STATUS_OFS, 32'h1);
		irq_is(1'b0);
		$display("test read done");
	endtask : t_read

	task automatic t_prot();
		logic [14:0] ad [6] = '{15'h01F0, 15'h0200, 15'h03F0, 15'h0400, 15'h7FF0, 15'h7FF0};
		logic [1:0] rg [6] = '{2'h2, 2'h2, 2'h1, 2'h1, 2'h0, 2'h3};
		int n;
		attempt(15'h0120, 14'h0, B_WR | B_EN, 1'b0, 1'b1, n);
		attempt(15'h0120, 14'h0, B_WR, 1'b1, 1'b1, n);
		for (int i = 0; i < 6; i++) begin
			write_protect_range <= rg[i];
			attempt(ad[i], 14'h0, B_WR | B_EN | B_RE, 1'b1, (i % 2 == 0), n);
		end
		$display("test protect done");
	endtask : t_prot

	task automatic t_write();
		logic [31:0] q;
		int n0;
		int n;
		n0 = np;
		attempt(15'h0125, 14'h1A5C, B_WR | B_EN | B_LO, 1'b1, 1'b0, n);
		check("latch_only", np - n0, 0);
		attempt(15'h0123, 14'h2B07, B_WR | B_EN, 1'b1, 1'b0, n);
		check("prog_cnt", np - n0, 16);
		check("prog_row", pa[14:4], 11'h012);
		check("word_new", pw[3], 14'h2B07);
		check("word_lat", pw[5], 14'h1A5C);
		check("word_ers", pw[0], `LATCH_ERASED);
		check("wr_time", (n - 1 >= WC + 16) && (n - 1 <= WC + 40), 1);
		rd(`CTRL_OFS, q);
		check("wr_clr", q & B_WR, 32'h0);
		attempt(15'h0127, 14'h0011, B_WR | B_EN, 1'b1, 1'b0, n);
		check("latch_rst", pw[5], `LATCH_ERASED);
		$display("test write done");
	endtask : t_write

	task automatic t_hold();
		logic [31:0] q;
		logic [31:0] h;
		logic [13:0] sv;
		int n;
		// Save a programmed word of the row before erasing it, then put it back
		wr(`ADDR_LOW_OFS, 32'h23);
		wr(`CTRL_OFS, B_RD);
		wait_done(n);
		rd(`DATA_LOW_OFS, q);
		rd(`DATA_HIGH_OFS, h);
		sv = {h[5:0], q[7:0]};
		check("saved", sv, 14'h0123 ^ 14'h2C3A);
		wr(`KEY_OFS, {24'h0, `UNLOCK_KEY1});
		wr(`KEY_OFS, {24'h0, `UNLOCK_KEY2});
		wr(`CTRL_OFS, B_WR | B_EN | B_RE);
		wr(`CTRL_OFS, 32'h0);
		rd(`CTRL_OFS, q);
		check("wr_held", q & B_WR, B_WR);
		@(negedge core_clk);
		check("wip", {write_in_progress, cpu_stall}, 2'h3);
		wait_done(n);
		attempt(15'h0123, sv, B_WR | B_EN, 1'b1, 1'b0, n);
		check("word_kept", pw[3], sv);
		$display("test hold done");
	endtask : t_hold

	task automatic t_bulk();
		@(negedge core_clk);
		check("ext_blk", ext_access_block, 1);
		@(posedge core_clk);
		ext_bulk_erase <= 1'b1;
		@(posedge core_clk);
		ext_bulk_erase <= 1'b0;
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
		check("ext_blk", ext_access_block, 0);
		@(posedge core_clk);
		$display("test bulk done");
	endtask : t_bulk

	// Main sequence
	initial begin
		rstn = 1'b0;
		hsel = 1'b1;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		code_protect = 1'b0;
		write_protect_range = 2'h3;
		ext_bulk_erase = 1'b0;
		write_aborted = 1'b1;
		repeat (12) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge core_clk);
		write_aborted <= 1'b0;
		t_boot();
		t_read();
		t_prot();
		t_write();
		t_hold();
		t_bulk();
		stop_test();
	end
endmodule : self_program_flash_control_tb_top
